// *** apdf_auth_port_filter.v ***
// Authentication port device filter: attach detect, identity capture,
// default or registered filtering, port power cycling and isolation.
// Assumes identity fields come from a bus monitor on this clock, and
// pin-level inputs (attach, tamper, self-test fail) are asynchronous.
`include "apdf_defines.vh"

module apdf_auth_port_filter (
  // Clock and reset
  input  wire        clk,
  input  wire        reset,
  // Channel selection and system state
  input  wire [1:0]  chanSel,
  input  wire        selfTestFail,
  input  wire        tamper,
  // Port attach and bus monitor identity
  input  wire        attachPin,
  input  wire        idValid,
  input  wire [15:0] idVid,
  input  wire [15:0] idPid,
  input  wire [7:0]  idClass,
  input  wire [7:0]  idProto,
  input  wire [15:0] idBcdUsb,
  input  wire [31:0] idSerial,
  // Registration list write port
  input  wire        authOk,
  input  wire        entWr,
  input  wire        entDel,
  input  wire [1:0]  entIdx,
  input  wire [4:0]  entMask,
  input  wire [15:0] entVid,
  input  wire [15:0] entPid,
  input  wire [7:0]  entClass,
  input  wire [7:0]  entProto,
  input  wire [31:0] entSerial,
  // Processor indications
  output reg         verifyReq,
  output reg         rejectEvt,
  output wire        listEmpty,
  // Port power and data path
  output reg  [3:0]  portPwrEn,
  output reg  [3:0]  pathEn,
  output reg         sessionKill
);

  localparam ST_IDLE = 3'd0;
  localparam ST_WAIT = 3'd1;
  localparam ST_RUN  = 3'd2;
  localparam ST_REJ  = 3'd3;
  localparam ST_ISO  = 3'd4;

  // ---------------------------------------------------------------
  // Input synchronisers
  // ---------------------------------------------------------------
  reg [2:0] syncA_r;
  reg [2:0] syncB_r;
  wire attached  = syncB_r[0];
  wire isolate   = syncB_r[1] | syncB_r[2];

  // Two flops per pin; only the second is read
  always @(posedge clk) begin
    if (reset) begin
      syncA_r <= 3'h0;
      syncB_r <= 3'h0;
    end else begin
      syncA_r <= {tamper, selfTestFail, attachPin};
      syncB_r <= syncA_r;
    end
  end

  // ---------------------------------------------------------------
  // Registration list
  // ---------------------------------------------------------------
  reg        entUsed_r  [0:3];
  reg [4:0]  entMask_r  [0:3];
  reg [15:0] entVid_r   [0:3];
  reg [15:0] entPid_r   [0:3];
  reg [7:0]  entClass_r [0:3];
  reg [7:0]  entProto_r [0:3];
  reg [31:0] entSer_r   [0:3];
  integer i;

  // Writes gated by authentication; tamper wipes the list
  always @(posedge clk) begin
    if (reset || isolate && syncB_r[2]) begin
      for (i = 0; i < `APDF_ENTRIES; i = i + 1) begin
        entUsed_r[i]  <= 1'b0;
        entMask_r[i]  <= 5'h00;
        entVid_r[i]   <= 16'h0000;
        entPid_r[i]   <= 16'h0000;
        entClass_r[i] <= 8'h00;
        entProto_r[i] <= 8'h00;
        entSer_r[i]   <= 32'h00000000;
      end
    end else if (authOk && entDel) begin
      entUsed_r[entIdx] <= 1'b0;
    end else if (authOk && entWr) begin
      entUsed_r[entIdx]  <= 1'b1;
      entMask_r[entIdx]  <= entMask;
      entVid_r[entIdx]   <= entVid;
      entPid_r[entIdx]   <= entPid;
      entClass_r[entIdx] <= entClass;
      entProto_r[entIdx] <= entProto;
      entSer_r[entIdx]   <= entSerial;
    end
  end

  assign listEmpty = ~(entUsed_r[0] | entUsed_r[1] | entUsed_r[2] | entUsed_r[3]);

  // ---------------------------------------------------------------
  // Identity capture and match
  // ---------------------------------------------------------------
  reg [15:0] capVid_r;
  reg [15:0] capPid_r;
  reg [7:0]  capClass_r;
  reg [7:0]  capProto_r;
  reg [15:0] capBcd_r;
  reg [31:0] capSer_r;

  // Latest identity kept for comparison only, never forwarded
  always @(posedge clk) begin
    if (reset) begin
      capVid_r   <= 16'h0000;
      capPid_r   <= 16'h0000;
      capClass_r <= 8'h00;
      capProto_r <= 8'h00;
      capBcd_r   <= 16'h0000;
      capSer_r   <= 32'h00000000;
    end else if (idValid && attached) begin
      capVid_r   <= idVid;
      capPid_r   <= idPid;
      capClass_r <= idClass;
      capProto_r <= idProto;
      capBcd_r   <= idBcdUsb;
      capSer_r   <= idSerial;
    end
  end

  // One entry: masked-off criteria are don't-care
  function entHit;
    input        used;
    input [4:0]  m;
    input [15:0] v;
    input [15:0] p;
    input [7:0]  c;
    input [7:0]  pr;
    input [31:0] s;
    begin
      entHit = used
        & (~m[`APDF_M_CLASS] | (c  == capClass_r))
        & (~m[`APDF_M_PROTO] | (pr == capProto_r))
        & (~m[`APDF_M_VID]   | (v  == capVid_r))
        & (~m[`APDF_M_PID]   | (p  == capPid_r))
        & (~m[`APDF_M_SER]   | (s  == capSer_r));
    end
  endfunction

  reg listHit;
  integer k;
  // Whitelist scan
  always @* begin
    listHit = 1'b0;
    for (k = 0; k < `APDF_ENTRIES; k = k + 1)
      if (entHit(entUsed_r[k], entMask_r[k], entVid_r[k], entPid_r[k],
                 entClass_r[k], entProto_r[k], entSer_r[k]))
        listHit = 1'b1;
  end

  // Default filter: smart-card reader, versioned token, biometric
  wire verOk   = (capBcd_r == `APDF_BCD_V11) | (capBcd_r == `APDF_BCD_V20);
  wire dfltHit = (capClass_r == `APDF_CLASS_SMARTCARD)
               | ((capClass_r == `APDF_CLASS_HID) & verOk)
               | (capClass_r == `APDF_CLASS_BIOMETRIC);
  // Registered list replaces the default entirely
  wire admit   = listEmpty ? dfltHit : listHit;

  // ---------------------------------------------------------------
  // Power-off timer on channel change
  // ---------------------------------------------------------------
  // Count truncated on purpose; 25 bits hold the full off period
  localparam [31:0] PWR_OFF_CYC = `APDF_PWR_OFF_CYC;
  reg [1:0]  chan_r;
  reg [24:0] offCnt_r;
  wire       pwrOff = (offCnt_r != 25'h0000000);

  // Full 1 s off lets the peripheral discharge its state
  always @(posedge clk) begin
    if (reset) begin
      chan_r   <= 2'h0;
      offCnt_r <= 25'h0000000;
    end else if (chanSel != chan_r) begin
      chan_r   <= chanSel;
      offCnt_r <= PWR_OFF_CYC[24:0];
    end else if (pwrOff) begin
      offCnt_r <= offCnt_r - 25'h0000001;
    end
  end

  // ---------------------------------------------------------------
  // Port control state machine
  // ---------------------------------------------------------------
  reg [2:0] state_r;
  reg [2:0] state_nxt;

  // Next state
  always @* begin
    state_nxt = state_r;
    case (state_r)
      ST_IDLE: if (attached && !pwrOff) state_nxt = ST_WAIT;
      ST_WAIT: if (!attached || pwrOff) state_nxt = ST_IDLE;
               else if (idValid) state_nxt = ST_RUN;
      ST_RUN:  if (!attached || pwrOff) state_nxt = ST_IDLE;
               else if (!admit) state_nxt = ST_REJ;
      ST_REJ:  if (!attached) state_nxt = ST_IDLE;
      ST_ISO:  state_nxt = ST_ISO;
      default: state_nxt = ST_IDLE;
    endcase
    if (isolate)
      state_nxt = ST_ISO;
  end

  // Registered outputs; ISO held until reset
  always @(posedge clk) begin
    if (reset) begin
      state_r     <= ST_IDLE;
      verifyReq   <= 1'b0;
      rejectEvt   <= 1'b0;
      portPwrEn   <= 4'h0;
      pathEn      <= 4'h0;
      sessionKill <= 1'b0;
    end else begin
      state_r     <= state_nxt;
      verifyReq   <= (state_r == ST_IDLE) && (state_nxt == ST_WAIT);
      rejectEvt   <= (state_r != ST_REJ) && (state_nxt == ST_REJ);
      sessionKill <= (state_r != ST_ISO) && (state_nxt == ST_ISO);
      portPwrEn   <= (state_nxt == ST_ISO || pwrOff) ? 4'h0
                     : (4'h1 << chan_r);
      // Path waits one cycle in RUN so a stale identity is never admitted
      pathEn      <= (state_r == ST_RUN && state_nxt == ST_RUN && admit)
                     ? (4'h1 << chan_r) : 4'h0;
    end
  end

endmodule

// *** apdf_card_model.sv ***
// Behavioural USB card reader with its bus monitor identity.
// Assumes the bench sets identity and plug state off the clock edge.
module apdf_card_model (
  // Bench side
  input wire         clk, plugIn, resend,
  input wire [15:0]  vid, pid, bcd,
  input wire [7:0]   cls,
  input wire [31:0]  ser,
  // Filter side
  input wire [3:0]   portPwrEn,
  input wire         verifyReq,
  output logic       attachPin = 1'b0, idValid = 1'b0,
  output wire [15:0] idVid, idPid, idBcdUsb,
  output wire [7:0]  idClass, idProto,
  output wire [31:0] idSerial
);
  timeunit 1ns;
  timeprecision 1ps;
  logic p, v;
  // Sample at the edge, drive just after it
  always @(posedge clk) begin
    p = plugIn && (portPwrEn != 4'h0);
    v = verifyReq || resend;
    #1;
    attachPin = p;
    idValid = v;
  end
  // Fields outside the valid cycle show inverted junk
  assign idVid = idValid ? vid : ~vid;
  assign idPid = idValid ? pid : ~pid;
  assign idBcdUsb = idValid ? bcd : ~bcd;
  assign idClass = idValid ? cls : ~cls;
  assign idProto = idValid ? 8'h00 : 8'hff;
  assign idSerial = idValid ? ser : ~ser;
endmodule

// *** apdf_check_properties.sv ***
// Concurrent checks on the port filter outputs.
// Assumes binding to apdf_auth_port_filter; sees its ports only.
// ----------------------------------------
// Checker
// ----------------------------------------
module apdf_check_properties (
  // Clock, reset and system state
  input wire       clk, reset, selfTestFail, tamper, attachPin,
  // List writes and indications
  input wire       authOk, entWr, entDel, verifyReq, rejectEvt, listEmpty, sessionKill,
  // Channel, power and path
  input wire [1:0] chanSel,
  input wire [3:0] portPwrEn, pathEn
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  // Power off and list empty at release, then channel 0 powered
  AST_RST_OUT: assert property ($fell(reset) |-> portPwrEn == 4'h0 && listEmpty
    ##1 portPwrEn == 4'h1) else $error("bad state after reset");
  // Power only on the settled channel
  AST_PWR_CHAN: assert property (portPwrEn != 4'h0 && chanSel == $past(chanSel)
    && chanSel == $past(chanSel, 2) |-> portPwrEn == (4'h1 << chanSel))
    else $error("power on wrong channel");
  AST_CHAN_OFF: assert property (chanSel != $past(chanSel) |-> ##2 (portPwrEn == 4'h0) [*8])
    else $error("power not removed on switch");
  AST_VERIFY: assert property ($rose(attachPin) && portPwrEn != 4'h0 |-> ##[2:5] verifyReq)
    else $error("no verify after attach");
  AST_DETACH: assert property ($fell(attachPin) |-> ##[1:4] pathEn == 4'h0)
    else $error("path kept after detach");
  AST_REJ_CUT: assert property (rejectEvt |-> pathEn == 4'h0 ##1 pathEn == 4'h0)
    else $error("path open on reject");
  AST_ISO: assert property ($rose(tamper || selfTestFail) |-> ##[1:5] sessionKill
    ##1 (portPwrEn == 4'h0 && pathEn == 4'h0) [*2]) else $error("no isolation");
  AST_LIST_GATE: assert property (!authOk && !tamper |=> listEmpty == $past(listEmpty))
    else $error("list changed without auth");
  AST_LIST_WR: assert property (authOk && entWr && !entDel && !tamper |=> !listEmpty)
    else $error("entry not stored");
endmodule
bind apdf_auth_port_filter apdf_check_properties i_chk (.clk, .reset, .selfTestFail,
  .tamper, .attachPin, .authOk, .entWr, .entDel, .verifyReq, .rejectEvt, .listEmpty,
  .sessionKill, .chanSel, .portPwrEn, .pathEn);

// *** apdf_defines.vh ***
// Constants for the authentication port device filter.
// Assumes a 25 MHz clock and a single synchronous reset.
`ifndef APDF_DEFINES_VH
`define APDF_DEFINES_VH
// ---------------------------------------------------------------
// Timing
// ---------------------------------------------------------------
`define APDF_CLK_HZ          25000000
`define APDF_PWR_OFF_MS      1000
`define APDF_PWR_OFF_CYC     (`APDF_CLK_HZ / 1000 * `APDF_PWR_OFF_MS)
// ---------------------------------------------------------------
// Sizes and class codes
// ---------------------------------------------------------------
`define APDF_CH_W            2
`define APDF_ENTRIES         4
`define APDF_IDX_W           2
`define APDF_CLASS_SMARTCARD 8'h0b
`define APDF_CLASS_BIOMETRIC 8'hff
`define APDF_CLASS_HID       8'h03
`define APDF_BCD_V11         16'h0110
`define APDF_BCD_V20         16'h0200
// ---------------------------------------------------------------
// Entry match-criteria mask bits
// ---------------------------------------------------------------
`define APDF_M_CLASS         0
`define APDF_M_PROTO         1
`define APDF_M_VID           2
`define APDF_M_PID           3
`define APDF_M_SER           4
`endif

// *** tb_auth_port_device_filter.sv ***
// Self-checking bench for the port filter.
// Assumes the card model and checker compile alongside.
module tb_auth_port_device_filter;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 0, reset = 1, selfTestFail = 0, tamper = 0, authOk = 0, entWr = 0, entDel = 0;
  logic plugIn = 0, resend = 0;
  logic [1:0] chanSel = 0, entIdx = 0;
  logic [4:0] entMask = 0;
  logic [15:0] entVid = 0, entPid = 0, vid = 0, pid = 0, bcd = 0;
  logic [7:0] entClass = 0, entProto = 0, cls = 0;
  logic [31:0] entSerial = 0, ser = 0;
  wire attachPin, idValid, verifyReq, rejectEvt, listEmpty, sessionKill;
  wire [15:0] idVid, idPid, idBcdUsb;
  wire [7:0] idClass, idProto;
  wire [31:0] idSerial;
  wire [3:0] portPwrEn, pathEn;
  int bad_count = 0, compares = 0;
  always #20 clk = ~clk;
  apdf_auth_port_filter i_dut (.clk, .reset, .chanSel, .selfTestFail, .tamper, .attachPin,
    .idValid, .idVid, .idPid, .idClass, .idProto, .idBcdUsb, .idSerial, .authOk, .entWr,
    .entDel, .entIdx, .entMask, .entVid, .entPid, .entClass, .entProto, .entSerial,
    .verifyReq, .rejectEvt, .listEmpty, .portPwrEn, .pathEn, .sessionKill);
  apdf_card_model i_card (.clk, .plugIn, .resend, .vid, .pid, .bcd, .cls, .ser, .portPwrEn,
    .verifyReq, .attachPin, .idValid, .idVid, .idPid, .idBcdUsb, .idClass, .idProto,
    .idSerial);
  task automatic chk(input string nm, input logic [3:0] seen, exp);
    compares++;
    if (seen !== exp) begin
      bad_count++;
      $display("BAD %s exp %h seen %h", nm, exp, seen);
    end
  endtask
  task results;
    if (bad_count == 0 && compares > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task do_reset;
    reset = 1;
    cyc(8);
    reset = 0;
    cyc(1);
    chk("pwr", portPwrEn, 4'h1);
    chk("empty", {3'h0, listEmpty}, 4'h1);
  endtask
  // One list write, strobes held a single cycle
  task ent(input logic ok, del, input logic [4:0] m);
    {authOk, entWr, entDel, entMask} = {ok, !del, del, m};
    {entVid, entPid, entClass, entSerial} = {16'h1234, 16'h5678, 8'h08, 32'hcafe0001};
    cyc(1);
    {authOk, entWr, entDel} = 3'h0;
    cyc(1);
  endtask
  // Plug a device, wait up to 40 cycles for admit, then unplug unless keep is set
  task automatic dev(input logic [7:0] c, input logic [15:0] b, v, input logic [31:0] s,
                     input logic ok, input logic keep = 0);
    logic rej;
    logic vr;
    rej = 0;
    vr = 0;
    {cls, bcd, vid, pid, ser, plugIn} = {c, b, v, 16'h5678, s, 1'b1};
    for (int i = 0; i < 40 && pathEn === 4'h0; i++) begin
      cyc(1);
      if (rejectEvt === 1'b1) rej = 1;
      if (verifyReq === 1'b1) vr = 1;
    end
    chk("verify", {3'h0, vr}, 4'h1);
    chk("path", pathEn, ok ? 4'h1 : 4'h0);
    chk("rej", {3'h0, rej}, {3'h0, !ok});
    if (!keep) begin
      plugIn = 0;
      cyc(8);
      chk("drop", pathEn, 4'h0);
    end
  endtask
  // Isolation with a session open
  task iso(input logic t);
    logic k;
    k = 0;
    dev(8'h0b, 16'h0200, 16'h0001, 32'h1, 1, 1);
    if (t) tamper = 1;
    else selfTestFail = 1;
    for (int i = 0; i < 10 && !k; i++) begin
      cyc(1);
      k = sessionKill === 1'b1;
    end
    cyc(1);
    chk("kill", {3'h0, k}, 4'h1);
    chk("isoPwr", portPwrEn | pathEn, 4'h0);
    chk("wipe", {3'h0, listEmpty}, 4'h1);
    {plugIn, selfTestFail} = 2'h0;
  endtask
  initial begin
    do_reset;
    dev(8'h0b, 16'h0200, 16'h0001, 32'h1, 1);
    dev(8'hff, 16'h0200, 16'h0001, 32'h1, 1);
    dev(8'h03, 16'h0110, 16'h0001, 32'h1, 1);
    dev(8'h03, 16'h0200, 16'h0001, 32'h1, 1);
    dev(8'h03, 16'h0300, 16'h0001, 32'h1, 0);
    dev(8'h08, 16'h0200, 16'h0001, 32'h1, 0);
    ent(0, 0, 5'h1c);
    chk("noAuth", {3'h0, listEmpty}, 4'h1);
    ent(1, 0, 5'h1c);
    chk("stored", {3'h0, listEmpty}, 4'h0);
    dev(8'h0b, 16'h0200, 16'h0001, 32'h1, 0);
    dev(8'h08, 16'h0200, 16'h1234, 32'hcafe0002, 0);
    dev(8'h08, 16'h0200, 16'h1234, 32'hcafe0001, 1, 1);
    ser = 32'hcafe0003;
    resend = 1;
    cyc(1);
    resend = 0;
    cyc(6);
    chk("recheck", pathEn, 4'h0);
    plugIn = 0;
    cyc(8);
    ent(1, 1, 5'h00);
    dev(8'h0b, 16'h0200, 16'h0001, 32'h1, 1);
    chanSel = 1;
    cyc(2);
    for (int i = 0; i < 100; i++) begin
      cyc(1);
      chk("offPwr", portPwrEn, 4'h0);
    end
    chanSel = 0;
    do_reset;
    iso(0);
    do_reset;
    ent(1, 0, 5'h00);
    iso(1);
    results;
  end
  // Hang guard, far beyond the expected run length
  initial begin
    #(40 * 20000);
    bad_count++;
    results;
  end
endmodule
